// [rtl/dcef_regs.svh]
// register offsets, field positions and reset values of the channel event block
`ifndef DCEF_REGS_SVH
`define DCEF_REGS_SVH
`define DCEF_OFF_FLAGS 4'h0
`define DCEF_OFF_MASK 4'h4
`define DCEF_OFF_ABORT 4'h8
`define DCEF_BIT_ERR 0
`define DCEF_BIT_ABORT 1
`define DCEF_BIT_CELL 2
`define DCEF_BIT_BLOCK 3
`define DCEF_BIT_HALF 4
`define DCEF_NFLAGS 5
`define DCEF_NCOND 3
`define DCEF_FLAGS_RST 5'h00
`define DCEF_MASK_RST 5'h00
`define DCEF_IRQNUM_RST 8'h00
`define DCEF_ABORT_EN_BIT 8
`endif

// [rtl/dcef_pkg.sv]
// types shared by the channel event block
package dcef_pkg;
	typedef logic [4:0] dcef_flags_t; // one bit per event
	typedef logic [15:0] dcef_size_t; // byte counts and pointers
	typedef enum logic [0:0] {
		DCEF_BUS_IDLE = 1'b0, // no access in flight
		DCEF_BUS_ACK = 1'b1 // answer cycle
	} dcef_bus_e;
endpackage

// [rtl/dcef_rise_detect.sv]
// turns match levels into one-cycle event pulses on their rising edge
`timescale 1ns/100ps
`default_nettype none
`include "dcef_regs.svh"
module dcef_rise_detect
	import dcef_pkg::*;
(
	input wire logic clock,
	input wire logic rst_n,
	input wire logic [`DCEF_NCOND-1:0] condLevel,
	output logic [`DCEF_NCOND-1:0] condPulse
);
	logic [`DCEF_NCOND-1:0] prevQ; // level seen last cycle

	// a condition that stays true fires only once, not every cycle
	genvar i;
	generate
		for (i = 0; i < `DCEF_NCOND; i++) begin : g_rise
			always_ff @(posedge clock) begin
				if (!rst_n) begin
					prevQ[i] <= 1'b0;
				end else begin
					prevQ[i] <= condLevel[i];
				end
			end
			assign condPulse[i] = condLevel[i] & ~prevQ[i];
		end
	endgenerate
endmodule
`default_nettype wire

// [rtl/dcef_channel_events.sv]
// per-channel event flags of a dma channel with an avalon-mm register slave
// Overview of operation
// - half flag when pointer equals half size
// - block flag when bytes reach larger size
// - pattern match also sets block flag
// - cell flag when cell bytes are moved
// - matching irq aborts transfer, sets abort flag
// - address error flag on bad address
`timescale 1ns/100ps
`default_nettype none
`include "dcef_regs.svh"
module dcef_channel_events
	import dcef_pkg::*;
(
	input wire logic clock,
	input wire logic rst_n,
	input wire logic [3:0] avsAddress,
	input wire logic avsRead,
	input wire logic avsWrite,
	input wire logic [31:0] avsWritedata,
	input wire logic [3:0] avsByteenable,
	output logic [31:0] avsReaddata,
	output logic avsWaitrequest,
	input wire logic [15:0] dest_pointer,
	input wire logic [15:0] dest_size,
	input wire logic [15:0] source_size,
	input wire logic [15:0] cell_size,
	input wire logic [15:0] blockBytes,
	input wire logic [15:0] cellBytes,
	input wire logic channelBusy,
	input wire logic patternMatch,
	input wire logic irqSeen,
	input wire logic [7:0] irqNumber,
	input wire logic srcAddrErr,
	input wire logic dstAddrErr,
	output logic abortTransfer,
	output logic eventIrq
);
	dcef_flags_t flagsQ; // sticky event flags
	dcef_flags_t maskQ; // interrupt enables, same layout
	logic [7:0] abort_request_number; // irq that ends the transfer
	logic abortEnQ; // abort matching armed
	dcef_bus_e busQ; // bus answer state
	logic [31:0] rdDataQ; // read data for the answer cycle
	logic accWr; // write taking effect this edge
	logic [`DCEF_NCOND-1:0] condLevel; // match levels
	logic [`DCEF_NCOND-1:0] condPulse; // match rising edges
	dcef_flags_t setVec; // events of this cycle
	dcef_flags_t clrVec; // bits written zero this cycle
	dcef_size_t blockTarget; // larger of the two sizes
	logic abortHit; // matching irq while running
	dcef_flags_t maskNext; // mask as it stands after this edge

	// address decode shared by read and write paths
	function automatic logic isReg(input logic [3:0] a, input logic [3:0] off);
		isReg = (a == off);
	endfunction

	// one wait cycle per access, answer in the second
	assign avsWaitrequest = (avsRead | avsWrite) & (busQ == DCEF_BUS_IDLE);
	assign accWr = avsWrite & (busQ == DCEF_BUS_ACK);
	assign avsReaddata = rdDataQ;

	// bus state: idle -> ack -> idle
	always_ff @(posedge clock) begin
		if (!rst_n) begin
			busQ <= DCEF_BUS_IDLE;
		end else begin
			case (busQ)
				DCEF_BUS_IDLE: begin
					if (avsRead | avsWrite) begin
						busQ <= DCEF_BUS_ACK;
					end
				end
				DCEF_BUS_ACK: begin
					busQ <= DCEF_BUS_IDLE;
				end
				default: begin
					busQ <= DCEF_BUS_IDLE;
				end
			endcase
		end
	end

	// read data captured in the wait cycle so it stands at the answer edge
	always_ff @(posedge clock) begin
		if (!rst_n) begin
			rdDataQ <= 32'h0000_0000;
		end else if (avsRead & (busQ == DCEF_BUS_IDLE)) begin
			if (isReg(avsAddress, `DCEF_OFF_FLAGS)) begin
				rdDataQ <= {27'h000_0000, flagsQ};
			end else if (isReg(avsAddress, `DCEF_OFF_MASK)) begin
				rdDataQ <= {27'h000_0000, maskQ};
			end else if (isReg(avsAddress, `DCEF_OFF_ABORT)) begin
				rdDataQ <= {23'h00_0000, abortEnQ, abort_request_number};
			end else begin
				// unmapped reads as zero
				rdDataQ <= 32'h0000_0000;
			end
		end
	end

	// mask and abort selection written by software
	always_ff @(posedge clock) begin
		if (!rst_n) begin
			maskQ <= `DCEF_MASK_RST;
			abort_request_number <= `DCEF_IRQNUM_RST;
			abortEnQ <= 1'b0;
		end else if (accWr) begin
			if (isReg(avsAddress, `DCEF_OFF_MASK) && avsByteenable[0]) begin
				maskQ <= avsWritedata[`DCEF_NFLAGS-1:0];
			end
			if (isReg(avsAddress, `DCEF_OFF_ABORT)) begin
				if (avsByteenable[0]) begin
					abort_request_number <= avsWritedata[7:0];
				end
				if (avsByteenable[1]) begin
					abortEnQ <= avsWritedata[`DCEF_ABORT_EN_BIT];
				end
			end
		end
	end

	// next mask, so the interrupt follows a mask write at the same edge
	// without it a flag already pending would raise the line one cycle late
	always_comb begin
		maskNext = maskQ;
		if (accWr && isReg(avsAddress, `DCEF_OFF_MASK) && avsByteenable[0]) begin
			maskNext = avsWritedata[`DCEF_NFLAGS-1:0];
		end
	end

	// the block ends at whichever size is larger
	assign blockTarget = (source_size > dest_size) ? source_size : dest_size;

	// match levels, zero sizes never match
	always_comb begin
		condLevel = '0;
		condLevel[0] = (dest_size != 16'h0000) && (dest_pointer == (dest_size >> 1));
		condLevel[1] = (blockTarget != 16'h0000) && (blockBytes == blockTarget);
		condLevel[2] = (cell_size != 16'h0000) && (cellBytes == cell_size);
	end

	dcef_rise_detect u_rise (
		.clock(clock),
		.rst_n(rst_n),
		.condLevel(condLevel),
		.condPulse(condPulse)
	);

	// abort only while a transfer runs and matching is armed
	assign abortHit = irqSeen & abortEnQ & channelBusy & (irqNumber == abort_request_number);

	// collect this cycle's events
	always_comb begin
		setVec = '0;
		setVec[`DCEF_BIT_HALF] = condPulse[0];
		setVec[`DCEF_BIT_BLOCK] = condPulse[1] | patternMatch;
		setVec[`DCEF_BIT_CELL] = condPulse[2];
		setVec[`DCEF_BIT_ABORT] = abortHit;
		setVec[`DCEF_BIT_ERR] = srcAddrErr | dstAddrErr;
	end

	// a zero written to a flag clears it; ones leave it alone
	always_comb begin
		clrVec = '0;
		if (accWr && isReg(avsAddress, `DCEF_OFF_FLAGS) && avsByteenable[0]) begin
			clrVec = ~avsWritedata[`DCEF_NFLAGS-1:0];
		end
	end

	// sticky flags; an event in the clearing cycle wins so it is never lost
	always_ff @(posedge clock) begin
		if (!rst_n) begin
			flagsQ <= `DCEF_FLAGS_RST;
		end else begin
			flagsQ <= (flagsQ & ~clrVec) | setVec;
		end
	end

	// abort command to the sequencer, one cycle
	always_ff @(posedge clock) begin
		if (!rst_n) begin
			abortTransfer <= 1'b0;
		end else begin
			abortTransfer <= abortHit;
		end
	end

	// level interrupt, registered to keep the output glitch free
	always_ff @(posedge clock) begin
		if (!rst_n) begin
			eventIrq <= 1'b0;
		end else begin
			eventIrq <= |(((flagsQ & ~clrVec) | setVec) & maskNext);
		end
	end

	default clocking cb @(posedge clock); endclocking
	default disable iff (!rst_n);

	a_half_flag_set: assert property ($rose(condLevel[0]) |=> flagsQ[`DCEF_BIT_HALF])
		else $error("half flag not set at midpoint");
	a_block_size_set: assert property ($rose(condLevel[1]) |=> flagsQ[`DCEF_BIT_BLOCK])
		else $error("block flag not set at block end");
	a_block_pattern: assert property (patternMatch |=> flagsQ[`DCEF_BIT_BLOCK])
		else $error("pattern match did not set block flag");
	a_cell_flag_set: assert property ($rose(condLevel[2]) |=> flagsQ[`DCEF_BIT_CELL])
		else $error("cell flag not set at cell end");
	a_abort_pulse: assert property (abortHit |=> abortTransfer && flagsQ[`DCEF_BIT_ABORT])
		else $error("abort not issued for matching irq");
	a_abort_needs_match: assert property (abortTransfer |-> $past(irqSeen) && $past(channelBusy))
		else $error("abort without matching irq");
	a_addr_err_set: assert property ((srcAddrErr || dstAddrErr) |=> flagsQ[`DCEF_BIT_ERR])
		else $error("address error flag not set");
	a_flag_sticky: assert property (flagsQ[`DCEF_BIT_ERR] && !clrVec[`DCEF_BIT_ERR] |=> flagsQ[`DCEF_BIT_ERR])
		else $error("error flag dropped without clear");
	a_flag_clear: assert property (clrVec[`DCEF_BIT_CELL] && !setVec[`DCEF_BIT_CELL] |=> !flagsQ[`DCEF_BIT_CELL])
		else $error("cell flag not cleared by zero write");
	a_bus_answer: assert property ((avsRead || avsWrite) |-> ##[0:1] !avsWaitrequest)
		else $error("bus answer later than one wait cycle");
	a_irq_follows: assert property (eventIrq == |(flagsQ & maskQ))
		else $error("interrupt does not follow unmasked flags");

	c_block_done: cover property ($rose(flagsQ[`DCEF_BIT_BLOCK]));
	c_abort_seen: cover property (abortTransfer);
	c_clear_flags: cover property (accWr && clrVec != '0 && flagsQ != '0);
	c_irq_raised: cover property ($rose(eventIrq));
endmodule
`default_nettype wire

// [test/dcef_seq_model.sv]
// far-side sequencer model: moves one byte a cycle until the block ends
`timescale 1ns/100ps
`default_nettype none
module dcef_seq_model
	import dcef_pkg::*;
(
	input wire logic clock,
	input wire logic rst_n,
	input wire logic go,
	input wire logic abortTransfer,
	input wire logic [15:0] dest_size,
	input wire logic [15:0] source_size,
	input wire logic [15:0] cell_size,
	output logic [15:0] dest_pointer,
	output logic [15:0] blockBytes,
	output logic [15:0] cellBytes,
	output logic channelBusy
);
	logic [15:0] lastByte; // block ends at the larger size
	assign lastByte = (source_size > dest_size) ? source_size : dest_size;
	assign dest_pointer = blockBytes;
	// counters hold after a stop so the flag logic sees no new match
	always_ff @(posedge clock) begin
		if (!rst_n) begin
			channelBusy <= 1'b0;
			blockBytes <= 16'h0;
			cellBytes <= 16'h0;
		end else if (go) begin
			channelBusy <= 1'b1;
			blockBytes <= 16'h0;
			cellBytes <= 16'h0;
		end else if (abortTransfer) begin
			channelBusy <= 1'b0;
		end else if (channelBusy) begin
			blockBytes <= blockBytes + 16'h1;
			cellBytes <= (cellBytes == cell_size) ? 16'h1 : cellBytes + 16'h1;
			channelBusy <= (blockBytes + 16'h1 != lastByte);
		end
	end
endmodule
`default_nettype wire

// [test/dcef_channel_events_bench.sv]
// self-checking bench of the channel event flags
`timescale 1ns/100ps
`default_nettype none
module dcef_channel_events_bench
	import dcef_pkg::*;
;
	logic clock, rst_n, avsRead, avsWrite, avsWaitrequest, channelBusy, patternMatch, irqSeen;
	logic srcAddrErr, dstAddrErr, abortTransfer, eventIrq, go;
	logic [3:0] avsAddress, avsByteenable;
	logic [31:0] avsReaddata, avsWritedata, q;
	logic [15:0] dest_pointer, dest_size, source_size, cell_size, blockBytes, cellBytes;
	logic [7:0] irqNumber;
	int checkCount, badCount, cyc, abortSeen;
	// event pulses and irq number, then the flags they raise
	logic [11:0] rowIn [5] = '{12'h800, 12'h400, 12'h200, 12'h133, 12'h15A};
	logic [4:0] rowOut [5] = '{5'h01, 5'h01, 5'h08, 5'h00, 5'h02};
	dcef_channel_events u_dut (.clock, .rst_n, .avsAddress, .avsRead, .avsWrite, .avsWritedata,
		.avsByteenable, .avsReaddata, .avsWaitrequest, .dest_pointer, .dest_size, .source_size,
		.cell_size, .blockBytes, .cellBytes, .channelBusy, .patternMatch, .irqSeen, .irqNumber,
		.srcAddrErr, .dstAddrErr, .abortTransfer, .eventIrq);
	dcef_seq_model u_seq (.clock, .rst_n, .go, .abortTransfer, .dest_size, .source_size,
		.cell_size, .dest_pointer, .blockBytes, .cellBytes, .channelBusy);
	initial begin
		clock = 1'b0;
		forever #50 clock = ~clock;
	end
	// abort pulses counted away from the edge to avoid a race
	always @(negedge clock) begin
		if (abortTransfer === 1'b1) begin
			abortSeen++;
		end
	end
	// a hang ends the run as a failure
	always @(posedge clock) begin
		cyc++;
		if (cyc == 3000) begin
			badCount++;
			reportAndStop();
		end
	end
	task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
		checkCount++;
		if (seen !== exp) begin
			badCount++;
			$display("mismatch %s expected %h seen %h", nm, exp, seen);
		end
	endtask
	// one access held to the rising edge where waitrequest is seen low
	// read in the active region, so values are those the slave sampled at that edge
	task automatic bus(input logic w, input logic [3:0] a, input logic [31:0] d);
		avsAddress <= a;
		avsWritedata <= d;
		avsWrite <= w;
		avsRead <= !w;
		do @(posedge clock); while (avsWaitrequest !== 1'b0);
		q = avsReaddata;
		avsWrite <= 1'b0;
		avsRead <= 1'b0;
		// idle edge so the next call never drives a strobe twice in one step
		@(posedge clock);
	endtask
	task automatic reportAndStop();
		$display("checks %0d mismatches %0d", checkCount, badCount);
		if (badCount == 0 && checkCount > 0) begin
			$display("SIMULATION PASSED");
		end else begin
			$display("SIMULATION FAILED");
		end
		$finish;
	endtask
	initial begin
		{rst_n, avsRead, avsWrite, go, patternMatch, irqSeen, srcAddrErr, dstAddrErr} = 8'h0;
		{avsAddress, avsWritedata, irqNumber} = 44'h0;
		avsByteenable = 4'hF;
		{dest_size, source_size, cell_size} = 48'h0;
		repeat (2) @(posedge clock);
		rst_n <= 1'b1;
		@(posedge clock);
		bus(0, 4'h0, 32'h0);
		chk("flags", q, 32'h0);
		bus(0, 4'h4, 32'h0);
		chk("mask", q, 32'h0);
		bus(0, 4'hC, 32'h0);
		chk("unmapped", q, 32'h0);
		bus(1, 4'h4, 32'h1F);
		bus(1, 4'h8, 32'h15A);
		// long block keeps the channel busy through the table
		source_size <= 16'hC8;
		go <= 1'b1;
		@(posedge clock);
		go <= 1'b0;
		for (int i = 0; i < 5; i++) begin
			bus(1, 4'h0, 32'h0);
			{srcAddrErr, dstAddrErr, patternMatch, irqSeen, irqNumber} <= rowIn[i];
			@(posedge clock);
			{srcAddrErr, dstAddrErr, patternMatch, irqSeen} <= 4'h0;
			repeat (2) @(negedge clock);
			chk("abort", abortSeen, 32'(rowOut[i][1]));
			chk("irq", 32'(eventIrq), 32'(|rowOut[i]));
			@(posedge clock);
			bus(0, 4'h0, 32'h0);
			chk("flags", q, 32'(rowOut[i]));
		end
		bus(1, 4'h0, 32'h0);
		bus(1, 4'h4, 32'h08);
		{dest_size, source_size, cell_size} <= {16'h8, 16'hC, 16'h4};
		go <= 1'b1;
		@(posedge clock);
		go <= 1'b0;
		do @(negedge clock); while (blockBytes !== 16'hA);
		chk("early block", 32'(eventIrq), 32'h0);
		do @(negedge clock); while (channelBusy !== 1'b0);
		repeat (3) @(negedge clock);
		chk("block irq", 32'(eventIrq), 32'h1);
		@(posedge clock);
		bus(0, 4'h0, 32'h0);
		chk("flags", q, 32'h1C);
		bus(1, 4'h0, 32'h0C);
		bus(0, 4'h0, 32'h0);
		chk("kept flags", q, 32'h0C);
		bus(1, 4'h4, 32'h0);
		@(negedge clock);
		chk("masked irq", 32'(eventIrq), 32'h0);
		// unmasking a flag that is already pending raises the line at once
		@(posedge clock);
		bus(1, 4'h4, 32'h04);
		@(negedge clock);
		chk("mask on pending", 32'(eventIrq), 32'h1);
		// reset in mid-run drops pending flags, mask and abort selection
		@(posedge clock);
		rst_n <= 1'b0;
		repeat (2) @(posedge clock);
		rst_n <= 1'b1;
		@(negedge clock);
		chk("reset irq", 32'(eventIrq), 32'h0);
		@(posedge clock);
		bus(0, 4'h0, 32'h0);
		chk("reset flags", q, 32'h0);
		bus(0, 4'h8, 32'h0);
		chk("reset abort", q, 32'h0);
		reportAndStop();
	end
endmodule
`default_nettype wire
